// [src/assf_device.sv]
/*
 * serial device end: oversampled asynchronous receiver with one or three
 * samples per bit, asynchronous transmitter, synchronous master transfer,
 * and transmit_queue / receive_queue with single move service requests.
 * assumes the mover end on the same clock; rxdPin is asynchronous.
 */
// Our own choices: the APB register port and the address map.
`timescale 1ns/1ps
module assf_device import assf_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH,   // queue depth, power of two
    parameter int HALF  = SCLK_HALF     // serial clock half period, cycles
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    assf_if.dev                   link,
    input  wire logic [OVS_W-1:0] oversampling_factor,
    input  wire logic             triple_sample_select,
    input  wire logic [POS_W-1:0] last_sample_tick,
    input  wire logic             txSingleMove,
    input  wire logic             rxSingleMove,
    input  wire logic             syncMaster,
    input  wire logic             rxdPin,
    output logic                  txdPin
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL_LVL = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_LVL = CW'(DEPTH / 2);
    localparam logic [7:0]    HALF_END = 8'(HALF - 1);

    // refuse shapes the pointers cannot serve
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || HALF < 1 || HALF > 255)
        $error("assf_device: bad DEPTH or HALF");

    // majority of three levels
    function automatic logic maj3(input logic a, input logic b,
                                  input logic c);
        maj3 = (a & b) | (a & c) | (b & c);
    endfunction : maj3

    // queue storage and pointers
    logic [DATA_W-1:0] txMem [DEPTH];
    logic [DATA_W-1:0] rxMem [DEPTH];
    logic [AW-1:0]     txWp_r, txRp_r, rxWp_r, rxRp_r;
    logic [CW-1:0]     txCnt_r, rxCnt_r, txCnt_nxt, rxCnt_nxt;
    logic              txBlk_r, rxBlk_r;        // one cycle after a move
    logic              txLost_r, rxLost_r, txLost_nxt, rxLost_nxt;
    logic [DATA_W-1:0] rxWord_r, rxWord_nxt;
    logic              txPush, txPop, rxPush, rxPop;
    logic              txFull, rxEmpty;
    logic [DATA_W-1:0] pushWord;                // word for receive_queue

    assign txFull  = (txCnt_r == FULL_LVL);
    assign rxEmpty = (rxCnt_r == '0);
    assign txPush  = link.txWrite && !txFull;
    assign rxPop   = link.rxRead && !rxEmpty;

    // single move: request per free transmit slot or stored receive word; else request at the half level
    // the block cycle makes each word earn its own request edge
    assign link.txReq = txSingleMove ? (!txFull && !txBlk_r)
                                     : (txCnt_r <= HALF_LVL);
    assign link.rxReq = rxSingleMove ? (!rxEmpty && !rxBlk_r)
                                     : (rxCnt_r >= HALF_LVL);
    assign link.txLost = txLost_r;
    assign link.rxLost = rxLost_r;
    assign link.rxWord = rxWord_r;

    // queue levels, lost events and fetched word
    always_comb begin
        txCnt_nxt  = txCnt_r + CW'(txPush) - CW'(txPop);
        rxCnt_nxt  = rxCnt_r + CW'(rxPush) - CW'(rxPop);
        rxWord_nxt = rxPop ? rxMem[rxRp_r] : rxWord_r;
        txLost_nxt = link.txWrite && (txFull || (txSingleMove && !link.txReq));
        rxLost_nxt = link.rxRead && (rxEmpty || (rxSingleMove && !link.rxReq));
    end

    // queue registers; a full receive_queue drops the new frame
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txWp_r   <= '0;
            txRp_r   <= '0;
            rxWp_r   <= '0;
            rxRp_r   <= '0;
            txCnt_r  <= '0;
            rxCnt_r  <= '0;
            txBlk_r  <= 1'b0;
            rxBlk_r  <= 1'b0;
            txLost_r <= 1'b0;
            rxLost_r <= 1'b0;
            rxWord_r <= WORD_RST;
        end else begin
            if (txPush) begin
                txMem[txWp_r] <= link.txWord;
                txWp_r <= txWp_r + 1'b1;
            end
            if (rxPush) begin
                rxMem[rxWp_r] <= pushWord;
                rxWp_r <= rxWp_r + 1'b1;
            end
            if (txPop)
                txRp_r <= txRp_r + 1'b1;
            if (rxPop)
                rxRp_r <= rxRp_r + 1'b1;
            txCnt_r  <= txCnt_nxt;
            rxCnt_r  <= rxCnt_nxt;
            txBlk_r  <= link.txWrite;
            rxBlk_r  <= link.rxRead;
            txLost_r <= txLost_nxt;
            rxLost_r <= rxLost_nxt;
            rxWord_r <= rxWord_nxt;
        end
    end

    // receive pin synchroniser: s1 feeds only s2
    logic s1_r, s2_r, s3_r, rxLvl_r, rxLvl_nxt;
    assign rxLvl_nxt = (s2_r == s3_r) ? s3_r : rxLvl_r;

    // asynchronous sampler state
    assf_rx_t          rxSt_r, rxSt_nxt;
    logic [OVS_W-1:0]  rxTick_r, rxTick_nxt;
    logic [3:0]        rxBit_r, rxBit_nxt;
    logic [DATA_W-1:0] rxShf_r, rxShf_nxt;
    logic              smpA_r, smpB_r, smpA_nxt, smpB_nxt;
    logic              lvlPrev_r;
    logic              aPush;                   // sampler frame done
    logic [OVS_W-1:0]  posLast, posA, posB;
    logic              bitVal;

    assign posLast = {1'b0, last_sample_tick};
    assign posB    = posLast - 5'h01;
    assign posA    = posLast - 5'h02;

    // sampler next state; tick 0 follows the cycle the start edge is seen
    always_comb begin
        rxSt_nxt   = rxSt_r;
        rxTick_nxt = rxTick_r;
        rxBit_nxt  = rxBit_r;
        rxShf_nxt  = rxShf_r;
        smpA_nxt   = smpA_r;
        smpB_nxt   = smpB_r;
        aPush      = 1'b0;
        bitVal = triple_sample_select ? maj3(smpA_r, smpB_r, rxLvl_r)
                                      : rxLvl_r;
        case (rxSt_r)
            RX_IDLE: begin
                // falling edge opens a frame unless in synchronous use
                if (lvlPrev_r && !rxLvl_r && !syncMaster) begin
                    rxSt_nxt   = RX_BITS;
                    rxTick_nxt = '0;
                    rxBit_nxt  = '0;
                end
            end
            RX_BITS: begin
                rxTick_nxt = (rxTick_r == oversampling_factor - 5'h01)
                           ? '0 : rxTick_r + 5'h01;
                if (rxTick_r == oversampling_factor - 5'h01)
                    rxBit_nxt = rxBit_r + 4'h1;
                // first two samples end at field
                if (rxTick_r == posA)
                    smpA_nxt = rxLvl_r;
                if (rxTick_r == posB)
                    smpB_nxt = rxLvl_r;
                if (rxTick_r == posLast) begin
                    if (rxBit_r == 4'h0 && bitVal)
                        rxSt_nxt = RX_IDLE;     // false start
                    else if (rxBit_r == 4'(FRAME_BITS - 1)) begin
                        rxSt_nxt = RX_IDLE;     // stop bit decided
                        aPush    = bitVal;      // framing error drops
                    end else if (rxBit_r != 4'h0)
                        rxShf_nxt = {bitVal, rxShf_r[DATA_W-1:1]};
                end
            end
            default: rxSt_nxt = RX_IDLE;
        endcase
    end

    // sampler registers
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            s1_r      <= 1'b1;
            s2_r      <= 1'b1;
            s3_r      <= 1'b1;
            rxLvl_r   <= 1'b1;
            lvlPrev_r <= 1'b1;
            rxSt_r    <= RX_IDLE;
            rxTick_r  <= '0;
            rxBit_r   <= '0;
            rxShf_r   <= WORD_RST;
            smpA_r    <= 1'b1;
            smpB_r    <= 1'b1;
        end else begin
            s1_r      <= rxdPin;
            s2_r      <= s1_r;
            s3_r      <= s2_r;
            rxLvl_r   <= rxLvl_nxt;
            lvlPrev_r <= rxLvl_r;
            rxSt_r    <= rxSt_nxt;
            rxTick_r  <= rxTick_nxt;
            rxBit_r   <= rxBit_nxt;
            rxShf_r   <= rxShf_nxt;
            smpA_r    <= smpA_nxt;
            smpB_r    <= smpB_nxt;
        end
    end

    // transmit engine state
    assf_tx_t          txSt_r, txSt_nxt;
    logic [FRAME_BITS-1:0] txShf_r, txShf_nxt;  // async frame, lsb first
    logic [DATA_W-1:0] sShf_r, sShf_nxt;        // sync receive shifter
    logic [OVS_W-1:0]  txTick_r, txTick_nxt;
    logic [7:0]        half_r, half_nxt;
    logic [3:0]        txBit_r, txBit_nxt;
    logic              sclk_r, sclk_nxt, frm_r, frm_nxt, txd_r, txd_nxt;
    logic              sPush;

    assign txPop    = (txSt_r == TX_IDLE) && (txCnt_r != '0);
    assign rxPush   = (aPush || sPush) && (rxCnt_r != FULL_LVL);
    assign pushWord = sPush ? sShf_r : rxShf_r;
    assign link.serial_clock_output = sclk_r;
    assign link.syncFrame = frm_r;
    assign txdPin = txd_r;

    // transmit next state; sync frames send msb first
    always_comb begin
        txSt_nxt   = txSt_r;
        txShf_nxt  = txShf_r;
        sShf_nxt   = sShf_r;
        txTick_nxt = txTick_r;
        half_nxt   = half_r;
        txBit_nxt  = txBit_r;
        sclk_nxt   = sclk_r;
        frm_nxt    = frm_r;
        txd_nxt    = txd_r;
        sPush      = 1'b0;
        case (txSt_r)
            TX_IDLE: begin
                if (txPop) begin
                    txBit_nxt  = '0;
                    txTick_nxt = '0;
                    half_nxt   = '0;
                    if (syncMaster) begin
                        txSt_nxt  = TX_SYNC;
                        frm_nxt   = 1'b1;
                        txShf_nxt = {2'b11, txMem[txRp_r]};
                        txd_nxt   = txMem[txRp_r][DATA_W-1];
                    end else begin
                        txSt_nxt  = TX_ASYNC;
                        txShf_nxt = {1'b1, txMem[txRp_r], 1'b0};
                        txd_nxt   = 1'b0;
                    end
                end
            end
            TX_ASYNC: begin
                txTick_nxt = txTick_r + 5'h01;
                if (txTick_r == oversampling_factor - 5'h01) begin
                    txTick_nxt = '0;
                    txBit_nxt  = txBit_r + 4'h1;
                    txShf_nxt  = {1'b1, txShf_r[FRAME_BITS-1:1]};
                    txd_nxt    = txShf_r[1];
                    if (txBit_r == 4'(FRAME_BITS - 1)) begin
                        txSt_nxt = TX_IDLE;
                        txd_nxt  = 1'b1;
                    end
                end
            end
            TX_SYNC: begin
                half_nxt = half_r + 8'h01;
                if (half_r == HALF_END) begin
                    half_nxt = '0;
                    sclk_nxt = !sclk_r;
                    if (!sclk_r) begin
                        sShf_nxt  = {sShf_r[DATA_W-2:0],
                                     link.master_receive_input};
                        txBit_nxt = txBit_r + 4'h1;
                    end else if (txBit_r == 4'(DATA_W)) begin
                        txSt_nxt = TX_IDLE;
                        frm_nxt  = 1'b0;
                        txd_nxt  = 1'b1;
                        sPush    = 1'b1;
                    end else begin
                        // data out moves on the falling edge
                        txShf_nxt = {txShf_r[FRAME_BITS-2:0], 1'b1};
                        txd_nxt   = txShf_r[DATA_W-2];
                    end
                end
            end
            default: txSt_nxt = TX_IDLE;
        endcase
    end

    // transmit registers; line idles high, clock idles low
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            txSt_r   <= TX_IDLE;
            txShf_r  <= '1;
            sShf_r   <= WORD_RST;
            txTick_r <= '0;
            half_r   <= '0;
            txBit_r  <= '0;
            sclk_r   <= 1'b0;
            frm_r    <= 1'b0;
            txd_r    <= 1'b1;
        end else begin
            txSt_r   <= txSt_nxt;
            txShf_r  <= txShf_nxt;
            sShf_r   <= sShf_nxt;
            txTick_r <= txTick_nxt;
            half_r   <= half_nxt;
            txBit_r  <= txBit_nxt;
            sclk_r   <= sclk_nxt;
            frm_r    <= frm_nxt;
            txd_r    <= txd_nxt;
        end
    end
endmodule : assf_device

// [src/assf_pkg.sv]
/*
 * shared constants of the serial sampling block and its fifo mover:
 * frame width, fifo depth, sampling field widths, serial clock timing,
 * mover register map, interrupt bit layout and state encodings.
 * assumes a single 40 mhz clock shared by both ends.
 */
package assf_pkg;
    // frame and fifo shape
    localparam int DATA_W      = 8;     // data bits per frame
    localparam int FIFO_DEPTH  = 8;     // entries per queue
    localparam int OVS_W       = 5;     // oversampling factor width
    localparam int POS_W       = 4;     // last sample tick width
    localparam int FRAME_BITS  = 10;    // start, data, stop
    // serial clock timing in synchronous master use
    localparam int CLK_NS      = 25;    // module clock period
    localparam int SCLK_HALF_NS = 100;  // serial clock half period
    localparam int SCLK_HALF   = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
    // mover register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CLEAR  = 8'h08;
    localparam logic [7:0] REG_ENABLE = 8'h0c;
    localparam logic [7:0] REG_TXDATA = 8'h10;
    localparam logic [7:0] REG_RXDATA = 8'h14;
    localparam logic [7:0] REG_SLAVE  = 8'h18;
    // interrupt bit positions (status, clear, enable share them)
    localparam int IRQ_TXDONE = 0;
    localparam int IRQ_RXGOT  = 1;
    localparam int IRQ_TXLOST = 2;
    localparam int IRQ_RXLOST = 3;
    localparam int IRQ_W      = 4;
    // field positions
    localparam int CTRL_EN_BIT  = 0;    // mover enable
    localparam int VALID_BIT    = 8;    // word valid flag in data regs
    // reset values
    localparam logic [IRQ_W-1:0]  IRQ_RST   = 4'h0;
    localparam logic [DATA_W-1:0] WORD_RST  = 8'h00;
    // receive sampler states
    typedef enum logic [1:0] {
        RX_IDLE = 2'b01,
        RX_BITS = 2'b10
    } assf_rx_t;
    // transmit engine states
    typedef enum logic [2:0] {
        TX_IDLE  = 3'b001,
        TX_ASYNC = 3'b010,
        TX_SYNC  = 3'b100
    } assf_tx_t;
endpackage : assf_pkg

// [src/assf_if.sv]
/*
 * link between the serial device and its fifo mover: queue write and
 * read strobes, service requests, lost events and the synchronous
 * serial pair toward the slave that the mover end models.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
interface assf_if;
    import assf_pkg::*;
    logic              txWrite;               // one word into transmit_queue
    logic [DATA_W-1:0] txWord;                // word written
    logic              txReq;                 // transmit service request
    logic              txLost;                // transmit transaction lost
    logic              rxRead;                // one word from receive_queue
    logic [DATA_W-1:0] rxWord;                // word fetched, next cycle
    logic              rxReq;                 // receive service request
    logic              rxLost;                // receive transaction lost
    logic              serial_clock_output;   // master serial clock
    logic              syncFrame;             // synchronous frame active
    logic              master_receive_input;  // slave data to master
    modport dev (
        input  txWrite, txWord, rxRead, master_receive_input,
        output txReq, txLost, rxWord, rxReq, rxLost,
        output serial_clock_output, syncFrame
    );
    modport mov (
        output txWrite, txWord, rxRead, master_receive_input,
        input  txReq, txLost, rxWord, rxReq, rxLost,
        input  serial_clock_output, syncFrame
    );
endinterface : assf_if

// [src/assf_mover.sv]
/*
 * mover end: apb slave with control, interrupt and data registers, a
 * one-word-per-request mover for both queues, and the synchronous slave
 * that answers the device's serial clock.
 * assumes the device end on the same clock; zero-wait apb.
 */
`timescale 1ns/1ps
module assf_mover import assf_pkg::*; (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    assf_if.mov              link,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq
);
    logic              en_r, en_nxt;           // mover enable
    logic [IRQ_W-1:0]  sts_r, sts_nxt, ena_r, ena_nxt;
    logic [DATA_W-1:0] hold_r, hold_nxt;        // word waiting to go
    logic              holdV_r, holdV_nxt;
    logic [DATA_W-1:0] rbuf_r, rbuf_nxt;        // last fetched word
    logic              rbufV_r, rbufV_nxt, rPend_r, rPend_nxt;
    logic [DATA_W-1:0] slv_r, slv_nxt;          // slave reply word
    logic [DATA_W-1:0] sShf_r, sShf_nxt;
    logic              txArm_r, txArm_nxt, rxArm_r, rxArm_nxt;
    logic              txPrev_r, rxPrev_r, sclkPrev_r;
    logic              wr, rd, txGo, rxGo;
    logic [IRQ_W-1:0]  ev, clr;
    logic [31:0]       rdat;

    assign wr     = psel && penable && pwrite;
    assign rd     = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign irq    = |(sts_r & ena_r);
    assign txGo = en_r && txArm_r && holdV_r;
    assign rxGo = en_r && rxArm_r && !rbufV_r && !rPend_r;
    assign link.txWrite = txGo;
    assign link.txWord  = hold_r;
    assign link.rxRead  = rxGo;
    assign link.master_receive_input = sShf_r[DATA_W-1];

    // read mux and error answer for unmapped offsets
    always_comb begin
        rdat    = '0;
        pslverr = 1'b0;
        case (paddr)
            REG_CTRL:   rdat[CTRL_EN_BIT] = en_r;
            REG_STATUS: rdat[IRQ_W-1:0] = sts_r;
            REG_CLEAR:  rdat = '0;
            REG_ENABLE: rdat[IRQ_W-1:0] = ena_r;
            REG_TXDATA: rdat[VALID_BIT:0] = {holdV_r, hold_r};
            REG_RXDATA: rdat[VALID_BIT:0] = {rbufV_r, rbuf_r};
            REG_SLAVE:  rdat[DATA_W-1:0] = slv_r;
            default:    pslverr = psel && penable;
        endcase
        prdata = rd ? rdat : '0;
    end

    // register, mover and slave next values
    always_comb begin
        ev = '0;
        ev[IRQ_TXDONE] = txGo;
        ev[IRQ_RXGOT]  = rPend_r;
        ev[IRQ_TXLOST] = link.txLost;
        ev[IRQ_RXLOST] = link.rxLost;
        clr = (wr && paddr == REG_CLEAR) ? pwdata[IRQ_W-1:0] : '0;
        // a new event beats a clear in the same cycle
        sts_nxt = (sts_r & ~clr) | ev;
        en_nxt  = (wr && paddr == REG_CTRL) ? pwdata[CTRL_EN_BIT] : en_r;
        ena_nxt = (wr && paddr == REG_ENABLE) ? pwdata[IRQ_W-1:0] : ena_r;
        slv_nxt = (wr && paddr == REG_SLAVE) ? pwdata[DATA_W-1:0] : slv_r;
        hold_nxt  = hold_r;
        holdV_nxt = holdV_r && !txGo;
        if (wr && paddr == REG_TXDATA) begin
            hold_nxt  = pwdata[DATA_W-1:0];
            holdV_nxt = 1'b1;
        end
        // the fetched word shows up one cycle after the strobe
        rPend_nxt = rxGo;
        rbuf_nxt  = rPend_r ? link.rxWord : rbuf_r;
        rbufV_nxt = rPend_r || (rbufV_r && !(rd && paddr == REG_RXDATA));
        // each request edge arms exactly one move
        txArm_nxt = (link.txReq && !txPrev_r) || (txArm_r && !txGo);
        rxArm_nxt = (link.rxReq && !rxPrev_r) || (rxArm_r && !rxGo);
        if (!link.syncFrame)
            sShf_nxt = slv_r;
        else if (sclkPrev_r && !link.serial_clock_output)
            sShf_nxt = {sShf_r[DATA_W-2:0], 1'b0};
        else
            sShf_nxt = sShf_r;
    end

    // registers of the mover end
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            en_r       <= 1'b0;
            sts_r      <= IRQ_RST;
            ena_r      <= IRQ_RST;
            hold_r     <= WORD_RST;
            holdV_r    <= 1'b0;
            rbuf_r     <= WORD_RST;
            rbufV_r    <= 1'b0;
            rPend_r    <= 1'b0;
            slv_r      <= WORD_RST;
            sShf_r     <= WORD_RST;
            txArm_r    <= 1'b0;
            rxArm_r    <= 1'b0;
            txPrev_r   <= 1'b0;
            rxPrev_r   <= 1'b0;
            sclkPrev_r <= 1'b0;
        end else begin
            en_r       <= en_nxt;
            sts_r      <= sts_nxt;
            ena_r      <= ena_nxt;
            hold_r     <= hold_nxt;
            holdV_r    <= holdV_nxt;
            rbuf_r     <= rbuf_nxt;
            rbufV_r    <= rbufV_nxt;
            rPend_r    <= rPend_nxt;
            slv_r      <= slv_nxt;
            sShf_r     <= sShf_nxt;
            txArm_r    <= txArm_nxt;
            rxArm_r    <= rxArm_nxt;
            txPrev_r   <= link.txReq;
            rxPrev_r   <= link.rxReq;
            sclkPrev_r <= link.serial_clock_output;
        end
    end
endmodule : assf_mover

// [testbench/assf_link_monitor.sv]
/*
 * checker on the device-mover link: requests, losses, serial clock.
 * assumes one clock domain and the device's default serial half period.
 */
`timescale 1ns/1ps
module assf_link_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic txSingleMove,
    input wire logic txWrite,
    input wire logic txReq,
    input wire logic txLost,
    input wire logic rxSingleMove,
    input wire logic rxRead,
    input wire logic rxReq,
    input wire logic rxLost,
    input wire logic serial_clock_output,
    input wire logic syncFrame,
    input wire logic master_receive_input
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    property p_txdrop; txSingleMove && txWrite |=> !txReq; endproperty
    a_txdrop: assert property (p_txdrop) else $error("tx request held");
    property p_rxdrop; rxSingleMove && rxRead |=> !rxReq; endproperty
    a_rxdrop: assert property (p_rxdrop) else $error("rx request held");
    property p_txref; txSingleMove && txWrite && !txReq |=> txLost; endproperty
    a_txref: assert property (p_txref) else $error("surplus write kept");
    property p_txcause; txLost |-> $past(txWrite); endproperty
    a_txcause: assert property (p_txcause) else $error("tx loss no write");
    property p_rxcause; rxLost |-> $past(rxRead); endproperty
    a_rxcause: assert property (p_rxcause) else $error("rx loss no read");
    property p_idle; !syncFrame |-> !serial_clock_output; endproperty
    a_idle: assert property (p_idle) else $error("serial clock not idle");
    property p_high; $rose(serial_clock_output)
        |-> serial_clock_output[*4] ##1 !serial_clock_output; endproperty
    a_high: assert property (p_high) else $error("serial clock phase");
    property p_hold; syncFrame && $rose(serial_clock_output)
        |-> $stable(master_receive_input); endproperty
    a_hold: assert property (p_hold) else $error("slave data moved");
endmodule : assf_link_monitor

// [testbench/async_serial_sampling_fifo_irq_tb.sv]
/* bench: apb to the mover, serial frames into the device; one clock */
`timescale 1ns/1ps
module async_serial_sampling_fifo_irq_tb import assf_pkg::*; ;
    logic clock = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic loop = 0, drv = 1, trip = 1, tsm = 1, rsm = 1, sm = 0, err;
    logic [7:0] paddr = 8'h00, b;       // apb address, random byte
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, txdPin;
    logic [4:0] ovs = 5'h10;            // ticks per bit
    logic [3:0] pos = 4'h9;             // last sample tick
    logic [7:0] expQ[$];                // expected received words
    int fail_count = 0, check_count = 0;
    always #12.5 clock = ~clock;
    assf_if link();
    assf_device i_assf_device (.clock, .sys_rst, .link,
        .oversampling_factor(ovs), .triple_sample_select(trip),
        .last_sample_tick(pos), .txSingleMove(tsm), .rxSingleMove(rsm),
        .syncMaster(sm), .rxdPin(loop ? txdPin : drv), .txdPin);
    assf_mover i_assf_mover (.clock, .sys_rst, .link, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq);
    assf_link_monitor i_assf_link_monitor (.clock, .sys_rst,
        .txSingleMove(tsm), .txWrite(link.txWrite), .txReq(link.txReq),
        .txLost(link.txLost), .rxSingleMove(rsm), .rxRead(link.rxRead),
        .rxReq(link.rxReq), .rxLost(link.rxLost), .syncFrame(link.syncFrame),
        .serial_clock_output(link.serial_clock_output),
        .master_receive_input(link.master_receive_input));
    task check(input logic [31:0] seen, exp, input string what);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task end_of_test;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    // one apb transfer; waits for pready under a bound
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; @(posedge clock);
        penable <= 1; n = 0;
        do begin @(posedge clock); n++; end while (pready !== 1 && n < 50);
        if (pready !== 1'b1) begin fail_count++; end_of_test; end
        rd = prdata; err = pslverr; psel <= 0; penable <= 0; @(posedge clock);
    endtask : apb
    // polls the receive register until a word is valid
    task rxwait;
        int n;
        n = 0;
        do begin apb(0, REG_RXDATA, 0); n++; end
        while (rd[VALID_BIT] !== 1'b1 && n < 200);
        if (n >= 200) begin fail_count++; end_of_test; end
    endtask : rxwait
    // data bit shows only at its sample ticks, one sample inverted
    // (first on even bits, last on odd), so a shifted window or a lone
    // last sample reads the wrong level
    task frame(input logic [7:0] w);
        logic [9:0] f;
        f = {1'b1, w, 1'b0};
        for (int k = 0; k < 10; k++) for (int t = 0; t < ovs; t++) begin
            drv <= (k == 0 || k == 9 || (t + 1 >= pos && t <= pos + 1
                && t != (k[0] ? pos + 1 : pos - 1))) ? f[k] : ~f[k];
            @(posedge clock);
        end
        drv <= 1;
    endtask : frame
    // scoreboard: each valid receive read takes the oldest note
    always @(posedge clock) if (psel && penable && pready && !pwrite &&
        paddr == REG_RXDATA && prdata[VALID_BIT] === 1'b1)
        check(prdata[7:0], expQ.pop_front(), "rxdata");
    initial begin
        void'($urandom(32'h8a12));
        repeat (12) @(posedge clock);
        sys_rst <= 0; @(posedge clock);
        apb(0, REG_STATUS, 0); check(rd, 32'h0, "status reset");
        apb(0, 8'hfc, 0); check({rd[30:0], err}, 32'h1, "unmapped");
        apb(1, REG_ENABLE, 32'h2); apb(1, REG_CTRL, 32'h1);
        for (int c = 0; c < 2; c++) begin
            ovs <= c ? 5'h08 : 5'h10; pos <= c ? 4'h5 : 4'h9;
            b = 8'($urandom); expQ.push_back(b); @(posedge clock);
            frame(b); rxwait;
            $display("sampling test %0d done", c);
        end
        check({31'h0, irq}, 32'h1, "irq raised");
        apb(1, REG_CLEAR, 32'hf); check({31'h0, irq}, 32'h0, "irq cleared");
        apb(1, REG_ENABLE, 32'h0); sm <= 1; b = 8'($urandom);
        expQ.push_back(b); apb(1, REG_SLAVE, {24'h0, b});
        apb(1, REG_TXDATA, 32'h5a); rxwait;
        $display("sync test done");
        // single sample and level style transmit requests on loopback
        sm <= 0; loop <= 1; trip <= 0; tsm <= 0; b = 8'($urandom);
        expQ.push_back(b); apb(1, REG_TXDATA, {24'h0, b}); rxwait;
        apb(0, REG_STATUS, 0); check(rd & 32'hc, 32'h0, "no loss");
        check({31'h0, irq}, 32'h0, "irq masked");
        $display("loopback test done");
        end_of_test;
    end
endmodule : async_serial_sampling_fifo_irq_tb
